/* fev_pkg.sv */
// constants, types and register map of the firmware entry vector logic
// assumes a 32-bit apb slave and a 64-bit program counter
package fev_pkg;

  // apb register byte offsets
  localparam logic [7:0] OFS_BASE_LO = 8'h00;
  localparam logic [7:0] OFS_BASE_HI = 8'h04;
  localparam logic [7:0] OFS_MODE    = 8'h08;
  localparam logic [7:0] OFS_CTL     = 8'h0C;
  localparam logic [7:0] OFS_STATUS  = 8'h10;
  localparam logic [7:0] OFS_LINK_LO = 8'h14;
  localparam logic [7:0] OFS_LINK_HI = 8'h18;
  localparam logic [7:0] OFS_EXC_LO  = 8'h1C;
  localparam logic [7:0] OFS_EXC_HI  = 8'h20;
  localparam logic [7:0] OFS_ENTRY   = 8'h24;

  // field positions
  localparam int CTL_HWE_BIT    = 0;
  localparam int CTL_SHADOW_BIT = 1;
  localparam int STS_FW_BIT     = 0;
  localparam int BASE_LSB       = 15;

  // reset values
  localparam logic [48:0] BASE_RST = 49'h0;
  localparam logic [1:0]  MODE_RST = 2'h0;
  localparam logic [1:0]  MODE_KERNEL = 2'h0;
  localparam logic [1:0]  CTL_RST  = 2'h0;

  // entry offsets from the handler base
  localparam logic [14:0] ENT_DTBM_D3   = 15'h0100;
  localparam logic [14:0] ENT_DTBM_D4   = 15'h0180;
  localparam logic [14:0] ENT_FLOAT_DIS = 15'h0200;
  localparam logic [14:0] ENT_MISALIGN  = 15'h0280;
  localparam logic [14:0] ENT_DTBM_SGL  = 15'h0300;
  localparam logic [14:0] ENT_DATA_FAULT_ENTRY    = 15'h0380;
  localparam logic [14:0] ENT_ILLEGAL   = 15'h0400;
  localparam logic [14:0] ENT_IACCESS   = 15'h0480;
  localparam logic [14:0] ENT_MCHECK    = 15'h0500;
  localparam logic [14:0] ENT_ITB_MISS  = 15'h0580;
  localparam logic [14:0] ENT_ARITHMETIC_TRAP_ENTRY     = 15'h0600;
  localparam logic [14:0] ENT_INTR      = 15'h0680;
  localparam logic [14:0] ENT_FCW       = 15'h0700;
  localparam logic [14:0] ENT_RESET     = 15'h0780;

  // call function field limits
  localparam logic [7:0] FN_PRIV_MAX = 8'h3F;
  localparam logic [7:0] FN_GAP_LO   = 8'h40;
  localparam logic [7:0] FN_GAP_HI   = 8'h7F;
  localparam logic [7:0] FN_MAX      = 8'hBF;

  // opcodes checked by the illegal-opcode decode
  localparam logic [5:0] OPC_LOW_MIN = 6'h01;
  localparam logic [5:0] OPC_LOW_MAX = 6'h07;
  localparam logic [5:0] OPC_HW_19   = 6'h19;
  localparam logic [5:0] OPC_HW_1B   = 6'h1B;
  localparam logic [5:0] OPC_HW_1D   = 6'h1D;
  localparam logic [5:0] OPC_HW_1E   = 6'h1E;
  localparam logic [5:0] OPC_HW_1F   = 6'h1F;
  localparam logic [5:0] OPC_FP_14   = 6'h14;
  localparam logic [5:0] OPC_FP_1C   = 6'h1C;

  localparam logic [63:0] INSN_BYTES = 64'h4;
  localparam int NUM_CAUSES = 14;

  // shadowed integer register numbers
  localparam logic [4:0] GPR_LOW_BASE  = 5'h04;
  localparam logic [4:0] GPR_HIGH_BASE = 5'h14;

  // pending causes, highest priority first
  typedef struct packed {
    logic dtbm_double_3;
    logic dtbm_double_4;
    logic float_disabled;
    logic misaligned;
    logic dtbm_single;
    logic data_fault;
    logic illegal_opcode;
    logic instr_access_violation;
    logic machine_check;
    logic itb_miss;
    logic arithmetic_trap;
    logic interrupt;
    logic float_control_write;
    logic reset_wakeup;
  } fev_causes_t;

  // fetch redirect toward the pipeline
  typedef struct packed {
    logic        valid;
    logic        flush;
    logic [63:0] pc;
  } fev_redirect_t;

  // return prediction stack push
  typedef struct packed {
    logic        valid;
    logic [63:0] addr;
  } fev_ras_t;

  typedef enum logic {FEV_IDLE, FEV_BUBBLE} fev_state_t;

endpackage

/* fev_shadow_map.sv */
// shadow register overlay lookup for the firmware entry vector logic
// assumes an integer register number from the same clock domain
`timescale 1ns/100ps
`default_nettype none

module fev_shadow_map (
  // lookup
  input  wire logic [4:0] gpr_idx,
  input  wire logic       firmware_mode,
  input  wire logic       shadow_enable,
  // result
  output logic            hit,
  output logic [2:0]      slot
);

  logic [4:0] low_ofs;
  logic [4:0] high_ofs;

  // registers 4..7 map to slots 0..3, 20..23 to slots 4..7
  always_comb begin
    low_ofs  = gpr_idx - fev_pkg::GPR_LOW_BASE;
    high_ofs = gpr_idx - fev_pkg::GPR_HIGH_BASE;
    hit      = 1'b0;
    slot     = 3'h0;
    if (firmware_mode && shadow_enable) begin
      if (gpr_idx >= fev_pkg::GPR_LOW_BASE && low_ofs < 5'h04) begin
        hit  = 1'b1;
        slot = {1'b0, low_ofs[1:0]};
      end else if (gpr_idx >= fev_pkg::GPR_HIGH_BASE && high_ofs < 5'h04) begin
        hit  = 1'b1;
        slot = {1'b1, high_ofs[1:0]};
      end
    end
  end

endmodule

`default_nettype wire

/* fev_entry_vector.sv */
// firmware entry vector logic: call entry, exception vectoring, apb registers
// assumes pipeline request inputs on pclk and an apb master on pclk
//
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

// Contract
// - privileged call is a jump, no abort
// - one bubble cycle, then fetch entry
// - next pc written to shadow r23; this block keeps it in link_reg instead
// - linkage bit 0 marks firmware mode
// - call pushes return address on stack
// - function 40-7f or above bf illegal
// - function 00-3f outside kernel illegal
// - entry upper bits from base, 13 set
// - function bits form entry, bit 0 set
// - exception vectors, saves and pushes pc
// - lowest offset wins among pending causes
// - double translation miss at 100/180
// - data faults at 280, 300, 380
// - float disabled 200, illegal 400
// - illegal opcode decode rules
// - instruction faults at 480 and 580
// - machine check 500, interrupts 680
// - reset and wakeup enter at 780
// - arithmetic 600, float control write 700
// - shadow overlay only in firmware mode
module fev_entry_vector (
  // clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // apb slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic                        pready,
  output logic [31:0]                 prdata,
  output logic                        pslverr,
  // privileged call from fetch
  input  wire logic                   call_valid,
  input  wire logic [7:0]             call_func,
  input  wire logic [63:0]            call_pc,
  output logic                        req_ready,
  // decoded instruction check
  input  wire logic                   dec_valid,
  input  wire logic [5:0]             dec_opcode,
  input  wire logic                   dec_ext_prec,
  input  wire logic                   dec_unimpl_func,
  // exception causes and faulting pc
  input  wire fev_pkg::fev_causes_t   exc_causes,
  input  wire logic [63:0]            exc_pc,
  input  wire logic                   wakeup,
  // firmware return
  input  wire logic                   fw_return,
  // shadow lookup
  input  wire logic [4:0]             gpr_idx,
  output logic                        shadow_hit,
  output logic [2:0]                  shadow_slot,
  // toward fetch
  output fev_pkg::fev_redirect_t      redirect,
  output logic                        fetch_bubble,
  output fev_pkg::fev_ras_t           ras_push,
  output logic                        firmware_mode
);

  // apb registers
  logic [48:0]         base_reg, base_next;
  logic [1:0]          mode_reg, mode_next;
  logic [1:0]          ctl_reg, ctl_next;
  // apb read path
  logic [31:0]         rdata_reg, rdata_next;
  logic                slverr_reg, slverr_next;
  // control state
  fev_pkg::fev_state_t state_reg, state_next;
  fev_pkg::fev_redirect_t redir_reg, redir_next;
  fev_pkg::fev_ras_t   ras_reg, ras_next;
  logic [63:0]         link_reg, link_next;
  logic [63:0]         exc_addr_reg, exc_addr_next;
  logic [63:0]         target_reg, target_next;
  logic [14:0]         entry_reg, entry_next;
  logic                fw_reg, fw_next;
  logic                rst_pend_reg, rst_pend_next;

  // decode helpers
  logic                apb_wr;
  logic                apb_setup;
  logic                fw_clear;
  logic                call_bad;
  logic                opc_illegal;
  logic [13:0]         cause_vec;
  logic                any_cause;
  logic [14:0]         sel_ofs;
  logic [63:0]         call_entry;
  logic [63:0]         fault_pc;

  fev_shadow_map u_shadow (
    .gpr_idx       (gpr_idx),
    .firmware_mode (fw_reg),
    .shadow_enable (ctl_reg[fev_pkg::CTL_SHADOW_BIT]),
    .hit           (shadow_hit),
    .slot          (shadow_slot)
  );

  // zero-wait apb; access phase writes, setup phase prepares read data
  assign pready    = 1'b1;
  assign prdata    = rdata_reg;
  assign pslverr   = slverr_reg;
  assign apb_wr    = psel && penable && pwrite;
  assign apb_setup = psel && !penable;
  assign fw_clear  = apb_wr && paddr == fev_pkg::OFS_STATUS && !pwdata[fev_pkg::STS_FW_BIT];

  // fetch facing outputs
  assign redirect      = redir_reg;
  assign ras_push      = ras_reg;
  assign firmware_mode = fw_reg;
  assign fetch_bubble  = (state_reg == fev_pkg::FEV_BUBBLE);
  assign req_ready     = (state_reg == fev_pkg::FEV_IDLE);

  // call function validity
  always_comb begin
    call_bad = 1'b0;
    if (call_func >= fev_pkg::FN_GAP_LO && call_func <= fev_pkg::FN_GAP_HI) begin
      call_bad = 1'b1;
    end else if (call_func > fev_pkg::FN_MAX) begin
      call_bad = 1'b1;
    end else if (call_func <= fev_pkg::FN_PRIV_MAX && mode_reg != fev_pkg::MODE_KERNEL) begin
      call_bad = 1'b1;
    end
  end

  // illegal opcode decode
  always_comb begin
    opc_illegal = 1'b0;
    if (dec_valid) begin
      if (dec_opcode >= fev_pkg::OPC_LOW_MIN && dec_opcode <= fev_pkg::OPC_LOW_MAX) begin
        opc_illegal = 1'b1;
      end else if ((dec_opcode == fev_pkg::OPC_HW_19 || dec_opcode == fev_pkg::OPC_HW_1B ||
                    dec_opcode == fev_pkg::OPC_HW_1D || dec_opcode == fev_pkg::OPC_HW_1E ||
                    dec_opcode == fev_pkg::OPC_HW_1F) &&
                   (!fw_reg || !ctl_reg[fev_pkg::CTL_HWE_BIT])) begin
        opc_illegal = 1'b1;
      end else if (dec_ext_prec) begin
        opc_illegal = 1'b1;
      end else if (dec_unimpl_func &&
                   (dec_opcode == fev_pkg::OPC_FP_14 || dec_opcode == fev_pkg::OPC_FP_1C)) begin
        opc_illegal = 1'b1;
      end
    end
  end

  // gather every pending cause, msb is highest priority
  always_comb begin
    cause_vec     = exc_causes;
    cause_vec[7]  = exc_causes.illegal_opcode || opc_illegal ||
                    (call_valid && call_bad);
    cause_vec[0]  = exc_causes.reset_wakeup || wakeup || rst_pend_reg;
    any_cause     = |cause_vec;
    fault_pc      = (call_valid && call_bad && !opc_illegal &&
                     !exc_causes.illegal_opcode) ? call_pc : exc_pc;
  end

  // fixed priority: first set bit from the top selects the offset
  always_comb begin
    sel_ofs = fev_pkg::ENT_RESET;
    if (cause_vec[13]) begin
      sel_ofs = fev_pkg::ENT_DTBM_D3;
    end else if (cause_vec[12]) begin
      sel_ofs = fev_pkg::ENT_DTBM_D4;
    end else if (cause_vec[11]) begin
      sel_ofs = fev_pkg::ENT_FLOAT_DIS;
    end else if (cause_vec[10]) begin
      sel_ofs = fev_pkg::ENT_MISALIGN;
    end else if (cause_vec[9]) begin
      sel_ofs = fev_pkg::ENT_DTBM_SGL;
    end else if (cause_vec[8]) begin
      sel_ofs = fev_pkg::ENT_DATA_FAULT_ENTRY;
    end else if (cause_vec[7]) begin
      sel_ofs = fev_pkg::ENT_ILLEGAL;
    end else if (cause_vec[6]) begin
      sel_ofs = fev_pkg::ENT_IACCESS;
    end else if (cause_vec[5]) begin
      sel_ofs = fev_pkg::ENT_MCHECK;
    end else if (cause_vec[4]) begin
      sel_ofs = fev_pkg::ENT_ITB_MISS;
    end else if (cause_vec[3]) begin
      sel_ofs = fev_pkg::ENT_ARITHMETIC_TRAP_ENTRY;
    end else if (cause_vec[2]) begin
      sel_ofs = fev_pkg::ENT_INTR;
    end else if (cause_vec[1]) begin
      sel_ofs = fev_pkg::ENT_FCW;
    end
  end

  // call entry address from base and function field
  always_comb begin
    call_entry = {base_reg, 1'b0, 1'b1,
                  call_func[7], call_func[5:0], 5'h00, 1'b1};
  end

  // entry sequencing, linkage, exception address and stack push
  always_comb begin
    state_next    = state_reg;
    redir_next    = '0;
    ras_next      = '0;
    link_next     = link_reg;
    exc_addr_next = exc_addr_reg;
    target_next   = target_reg;
    entry_next    = entry_reg;
    rst_pend_next = rst_pend_reg;
    fw_next       = fw_reg;
    if (fw_return || fw_clear) begin
      fw_next = 1'b0;
    end
    case (state_reg)
      fev_pkg::FEV_IDLE: begin
        if (any_cause) begin
          redir_next.valid = 1'b1;
          redir_next.flush = 1'b1;
          redir_next.pc    = {base_reg, sel_ofs[14:1], 1'b1};
          exc_addr_next    = fault_pc;
          ras_next.valid   = 1'b1;
          ras_next.addr    = fault_pc;
          entry_next       = sel_ofs;
          rst_pend_next    = 1'b0;
          fw_next          = 1'b1;
        end else if (call_valid) begin
          link_next      = (call_pc + fev_pkg::INSN_BYTES) |
                           {63'h0, fw_reg};
          ras_next.valid = 1'b1;
          ras_next.addr  = call_pc + fev_pkg::INSN_BYTES;
          target_next    = call_entry;
          entry_next     = call_entry[14:0];
          state_next     = fev_pkg::FEV_BUBBLE;
        end
      end
      fev_pkg::FEV_BUBBLE: begin
        redir_next.valid = 1'b1;
        redir_next.flush = 1'b0;
        redir_next.pc    = target_reg;
        fw_next          = 1'b1;
        state_next       = fev_pkg::FEV_IDLE;
      end
      default: begin
        state_next = fev_pkg::FEV_IDLE;
      end
    endcase
  end

  // control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg    <= fev_pkg::FEV_IDLE;
      redir_reg    <= '0;
      ras_reg      <= '0;
      link_reg     <= '0;
      exc_addr_reg <= '0;
      target_reg   <= '0;
      entry_reg    <= '0;
      fw_reg       <= 1'b1;
      rst_pend_reg <= 1'b1;
    end else begin
      state_reg    <= state_next;
      redir_reg    <= redir_next;
      ras_reg      <= ras_next;
      link_reg     <= link_next;
      exc_addr_reg <= exc_addr_next;
      target_reg   <= target_next;
      entry_reg    <= entry_next;
      fw_reg       <= fw_next;
      rst_pend_reg <= rst_pend_next;
    end
  end

  // software writable registers
  always_comb begin
    base_next = base_reg;
    mode_next = mode_reg;
    ctl_next  = ctl_reg;
    if (apb_wr) begin
      if (paddr == fev_pkg::OFS_BASE_LO) begin
        base_next[16:0] = pwdata[31:fev_pkg::BASE_LSB];
      end else if (paddr == fev_pkg::OFS_BASE_HI) begin
        base_next[48:17] = pwdata;
      end else if (paddr == fev_pkg::OFS_MODE) begin
        mode_next = pwdata[1:0];
      end else if (paddr == fev_pkg::OFS_CTL) begin
        ctl_next = pwdata[1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_reg <= fev_pkg::BASE_RST;
      mode_reg <= fev_pkg::MODE_RST;
      ctl_reg  <= fev_pkg::CTL_RST;
    end else begin
      base_reg <= base_next;
      mode_reg <= mode_next;
      ctl_reg  <= ctl_next;
    end
  end

  // read mux, latched in the setup phase; unmapped answers slverr
  always_comb begin
    rdata_next  = rdata_reg;
    slverr_next = slverr_reg;
    if (apb_setup) begin
      rdata_next  = 32'h0;
      slverr_next = 1'b0;
      if (paddr == fev_pkg::OFS_BASE_LO) begin
        rdata_next = {base_reg[16:0], 15'h0};
      end else if (paddr == fev_pkg::OFS_BASE_HI) begin
        rdata_next = base_reg[48:17];
      end else if (paddr == fev_pkg::OFS_MODE) begin
        rdata_next = {30'h0, mode_reg};
      end else if (paddr == fev_pkg::OFS_CTL) begin
        rdata_next = {30'h0, ctl_reg};
      end else if (paddr == fev_pkg::OFS_STATUS) begin
        rdata_next = {31'h0, fw_reg};
      end else if (paddr == fev_pkg::OFS_LINK_LO) begin
        rdata_next = link_reg[31:0];
      end else if (paddr == fev_pkg::OFS_LINK_HI) begin
        rdata_next = link_reg[63:32];
      end else if (paddr == fev_pkg::OFS_EXC_LO) begin
        rdata_next = exc_addr_reg[31:0];
      end else if (paddr == fev_pkg::OFS_EXC_HI) begin
        rdata_next = exc_addr_reg[63:32];
      end else if (paddr == fev_pkg::OFS_ENTRY) begin
        rdata_next = {17'h0, entry_reg};
      end else begin
        slverr_next = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_reg  <= 32'h0;
      slverr_reg <= 1'b0;
    end else begin
      rdata_reg  <= rdata_next;
      slverr_reg <= slverr_next;
    end
  end

endmodule

`default_nettype wire

/* fev_entry_vector_assertions.sv */
// port checker for the firmware entry vector logic
// assumes one pclk domain, bound to the top module below
`timescale 1ns/100ps
`default_nettype none
module fev_entry_vector_assertions (
  // clock and reset
  input wire logic                   pclk,
  input wire logic                   presetn,
  // requests
  input wire logic                   call_valid,
  input wire logic [7:0]             call_func,
  input wire logic [63:0]            call_pc,
  input wire logic                   req_ready,
  input wire logic                   dec_valid,
  input wire fev_pkg::fev_causes_t   exc_causes,
  input wire logic [63:0]            exc_pc,
  input wire logic                   wakeup,
  // results
  input wire logic                   shadow_hit,
  input wire fev_pkg::fev_redirect_t redirect,
  input wire logic                   fetch_bubble,
  input wire fev_pkg::fev_ras_t      ras_push,
  input wire logic                   firmware_mode
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // lowest offset of the pending causes
  function automatic logic [14:0] ofs(input logic [13:0] c);
    ofs = 15'h0;
    for (int k = 0; k < 14; k++)
      if (c[k]) ofs = 15'h0100 + 15'(13 - k) * 15'h0080;
  endfunction
  // call entry low bits
  function automatic logic [14:0] ent(input logic [7:0] f);
    ent = {2'h1, f[7], f[5:0], 6'h01};
  endfunction
  // idle block, no competing request
  sequence quiet;
    $past(presetn) && !dec_valid && !wakeup && req_ready;
  endsequence
  sequence call_in;
    quiet ##0 call_valid && exc_causes == '0;
  endsequence
  sequence call_ok;
    call_in ##0 call_func[7:6] == 2'h2;
  endsequence
  sequence call_bad;
    call_in ##0 call_func[6] == 1'h1;
  endsequence
  sequence exc_take;
    quiet ##0 !call_valid && exc_causes != '0;
  endsequence
  chk_call_push: assert property (
    call_ok |=> fetch_bubble && !req_ready && ras_push.valid
      && ras_push.addr == $past(call_pc) + 64'h4)
    else $error("call push wrong");
  chk_call_entry: assert property (
    call_ok |=> ##1 redirect.valid && !redirect.flush && redirect.pc[14:0] == ent($past(call_func, 2)))
    else $error("call entry wrong");
  chk_bubble_one: assert property (
    fetch_bubble |-> !req_ready ##1 !fetch_bubble)
    else $error("bubble too long");
  chk_bad_call: assert property (
    call_bad |=> redirect.valid && redirect.flush && redirect.pc[14:0] == 15'h0401
      && ras_push.addr == $past(call_pc))
    else $error("bad call not diverted");
  chk_exc_entry: assert property (
    exc_take |=> redirect.valid && redirect.flush
      && redirect.pc[14:0] == (ofs($past(exc_causes)) | 15'h0001))
    else $error("wrong vector");
  chk_exc_save: assert property (
    exc_take |=> ras_push.valid && ras_push.addr == $past(exc_pc) && firmware_mode)
    else $error("fault pc not saved");
  chk_reset_entry: assert property (
    presetn && !$past(presetn) && exc_causes == '0 |=> redirect.valid && redirect.pc[14:0] == 15'h0781)
    else $error("reset entry missing");
  chk_shadow_off: assert property (
    !firmware_mode |-> !shadow_hit)
    else $error("shadow hit out of fw mode");
endmodule
bind fev_entry_vector fev_entry_vector_assertions chk (.*);
`default_nettype wire

/* fev_fetch_model.sv */
// fetch-side model that issues privileged calls
// assumes req_ready from the entry vector block on pclk
`timescale 1ns/100ps
`default_nettype none
module fev_fetch_model (
  // clock
  input  wire logic   pclk,
  // call handshake
  input  wire logic   req_ready,
  output logic        call_valid,
  output logic [7:0]  call_func,
  output logic [63:0] call_pc
);
  // idle request lines
  initial begin
    call_valid = 1'h0;
    call_func  = 8'h00;
    call_pc    = 64'h0;
  end
  // hold a call until taken, then show the inverse
  task automatic issue(input logic [7:0] f, input logic [63:0] pc, input int lag);
    repeat (lag + 1) @(posedge pclk);
    call_valid <= 1'h1;
    call_func  <= f;
    call_pc    <= pc;
    do @(posedge pclk); while (req_ready !== 1'h1);
    call_valid <= 1'h0;
    call_func  <= ~f;
    call_pc    <= ~pc;
  endtask
endmodule
`default_nettype wire

/* testbench.sv */
// self-checking bench for the entry vector logic
// assumes the fetch model and checker files are compiled first
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic                   pclk, presetn, psel, penable, pwrite, pready, pslverr, err, ill;
  logic [7:0]             paddr, call_func;
  logic [31:0]            pwdata, prdata, q, r, rs;
  logic                   call_valid, req_ready, dec_valid, dec_ext_prec, dec_unimpl_func;
  logic                   wakeup, fw_return, shadow_hit, fetch_bubble, firmware_mode, fw, ras_on;
  logic [63:0]            call_pc, exc_pc, base, pc;
  logic [5:0]             dec_opcode;
  logic [13:0]            causes;
  logic [4:0]             gpr_idx;
  logic [2:0]             shadow_slot;
  fev_pkg::fev_causes_t   exc_causes;
  fev_pkg::fev_redirect_t redirect, e;
  fev_pkg::fev_ras_t      ras_push;
  fev_pkg::fev_redirect_t exp_q[$];
  logic [63:0]            ras_q[$];
  logic [10:0]            dtab[12];
  logic [7:0]             ftab[8];
  int                     fails, n_compared;

  fev_entry_vector dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .call_valid(call_valid), .call_func(call_func), .call_pc(call_pc), .req_ready(req_ready),
    .dec_valid(dec_valid), .dec_opcode(dec_opcode), .dec_ext_prec(dec_ext_prec),
    .dec_unimpl_func(dec_unimpl_func), .exc_causes(exc_causes), .exc_pc(exc_pc),
    .wakeup(wakeup), .fw_return(fw_return), .gpr_idx(gpr_idx), .shadow_hit(shadow_hit),
    .shadow_slot(shadow_slot), .redirect(redirect), .fetch_bubble(fetch_bubble),
    .ras_push(ras_push), .firmware_mode(firmware_mode));
  fev_fetch_model fetch (.pclk(pclk), .req_ready(req_ready), .call_valid(call_valid),
    .call_func(call_func), .call_pc(call_pc));

  // free-running clock
  initial begin
    pclk = 1'h0;
    forever #5 pclk = ~pclk;
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    finish_test;
  end

  function automatic logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  // lowest offset of the pending causes
  function automatic logic [14:0] ofs(input logic [13:0] c);
    ofs = 15'h0;
    for (int k = 0; k < 14; k++)
      if (c[k]) ofs = 15'h0100 + 15'(13 - k) * 15'h0080;
  endfunction
  task automatic check(input string what, input logic [65:0] seen, input logic [65:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic note(input logic fl, input logic [14:0] lo, input logic [63:0] ra);
    exp_q.push_back({1'h1, fl, base[63:15], lo});
    ras_q.push_back(ra);
  endtask
  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'h1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    q = prdata;
    err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic er);
    apb(1'h0, a, 32'h0);
    check("prdata", q, x);
    check("pslverr", err, er);
  endtask
  task automatic finish_test;
    $display("compared %0d, mismatched %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // compare outputs with the oldest notes
  always @(negedge pclk) begin
    if (presetn && redirect.valid) begin
      e = exp_q.size() > 0 ? exp_q.pop_front() : '0;
      check("redirect", redirect, e);
    end
    if (ras_on && ras_push.valid)
      check("ras_push", ras_push.addr, ras_q.size() > 0 ? ras_q.pop_front() : '0);
  end

  // main sequence
  initial begin
    rs = 32'h59;
    {fails, n_compared} = '0;
    {psel, penable, pwrite, dec_valid, dec_ext_prec, dec_unimpl_func, wakeup, fw_return} = '0;
    {paddr, pwdata, dec_opcode, gpr_idx, exc_causes, exc_pc, base, presetn, ras_on} = '0;
    fw = 1'h1;
    exp_q.push_back({2'h3, 64'h781});
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    repeat (4) @(posedge pclk);
    ras_on = 1'h1;
    apb(1'h1, fev_pkg::OFS_LINK_LO, 32'hFFFF_FFFF);
    for (int i = 0; i < 9; i++)
      rd(8'(i * 4), 32'(i == 4), 1'h0);
    rd(8'h28, 32'h0, 1'h1);
    base = {xs(), xs() & 32'hFFFF_8000};
    apb(1'h1, fev_pkg::OFS_BASE_LO, base[31:0]);
    apb(1'h1, fev_pkg::OFS_BASE_HI, base[63:32]);
    apb(1'h1, fev_pkg::OFS_STATUS, 32'h0);
    fw = 1'h0;
    $display("test registers done");
    // call functions, kernel then user mode
    ftab = '{8'h00, 8'h3F, 8'h40, 8'h7F, 8'h80, 8'hBF, 8'hC0, 8'hFF};
    for (int m = 0; m < 2; m++) begin
      apb(1'h1, fev_pkg::OFS_MODE, 32'(m));
      foreach (ftab[i]) begin
        pc = {xs(), xs() & 32'hFFFF_FFFC};
        ill = ftab[i][6] || (ftab[i] < 8'h40 && m != 0);
        if (ill) note(1'h1, 15'h0401, pc);
        else note(1'h0, {2'h1, ftab[i][7], ftab[i][5:0], 6'h01}, pc + 64'h4);
        fetch.issue(ftab[i], pc, i % 3);
        repeat (3) @(posedge pclk);
        if (!ill) rd(fev_pkg::OFS_LINK_LO, (pc[31:0] + 32'h4) | 32'(fw), 1'h0);
        fw = 1'h1;
      end
    end
    // back-to-back calls, the second raised as the bubble ends
    note(1'h0, 15'h3041, pc + 64'h4);
    note(1'h0, 15'h3081, pc + 64'h14);
    fetch.issue(8'h81, pc, 0);
    fetch.issue(8'h82, pc + 64'h10, 0);
    repeat (4) @(posedge pclk);
    $display("test calls done");
    // single causes, then random mixes
    for (int k = 0; k < 22; k++) begin
      r = xs();
      causes = k < 14 ? 14'(1 << k) : r[13:0] | 14'h0001;
      pc = {xs(), xs() & 32'hFFFF_FFFC};
      note(1'h1, ofs(causes) | 15'h0001, pc);
      @(posedge pclk);
      exc_causes <= causes;
      exc_pc <= pc;
      @(posedge pclk);
      exc_causes <= 14'h0;
      exc_pc <= ~pc;
      repeat (2) @(posedge pclk);
    end
    rd(fev_pkg::OFS_EXC_LO, pc[31:0], 1'h0);
    $display("test exceptions done");
    // opcode decode: {hw enable, clear mode, illegal, ext, unimpl, opcode}
    dtab = '{11'h101, 11'h107, 11'h008, 11'h119, 11'h154, 11'h15C,
             11'h01C, 11'h196, 11'h41B, 11'h41D, 11'h41E, 11'h71F};
    foreach (dtab[i]) begin
      apb(1'h1, fev_pkg::OFS_CTL, {30'h0, 1'h1, dtab[i][10]});
      if (dtab[i][9]) apb(1'h1, fev_pkg::OFS_STATUS, 32'h0);
      pc = {xs(), xs() & 32'hFFFF_FFFC};
      if (dtab[i][8]) note(1'h1, 15'h0401, pc);
      @(posedge pclk);
      dec_valid <= 1'h1;
      {dec_ext_prec, dec_unimpl_func, dec_opcode} <= dtab[i][7:0];
      exc_pc <= pc;
      @(posedge pclk);
      dec_valid <= 1'h0;
      exc_pc <= ~pc;
      repeat (2) @(posedge pclk);
    end
    ras_on = 1'h0;
    note(1'h1, 15'h0781, exc_pc);
    @(posedge pclk);
    wakeup <= 1'h1;
    @(posedge pclk);
    wakeup <= 1'h0;
    repeat (3) @(posedge pclk);
    $display("test decode done");
    // shadow overlay in, then out of firmware mode
    for (int i = 0; i < 64; i++) begin
      if (i == 32) begin
        @(posedge pclk);
        fw_return <= 1'h1;
        @(posedge pclk);
        fw_return <= 1'h0;
      end
      @(posedge pclk);
      gpr_idx <= 5'(i);
      @(negedge pclk);
      ill = i < 32 && (i[4:2] == 3'h1 || i[4:2] == 3'h5);
      check("shadow_hit", shadow_hit, ill);
      if (ill) check("shadow_slot", shadow_slot, {i[4], i[1:0]});
    end
    $display("test shadow done");
    check("pending", exp_q.size(), 0);
    finish_test;
  end
endmodule
`default_nettype wire
